//--- verilog/csp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module csp_serial_port
    import csp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic serial_bit_clock,
    input wire logic serial_data_in,
    input wire logic alternate_serial_input,
    input wire logic alt_input_select,
    input wire logic secondary_request_pin,
    input wire logic [2:0] cascade_count,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic frame_sync_pulse,
    output logic serial_data_out,
    output logic serial_data_oe_n
);

    // two-flop synchronisers for pins
    logic [1:0] sclk_s_r, din_s_r, alt_s_r, req_s_r;
    logic sclk_d_r;
    logic [1:0] sel_s_r;
    logic [2:0] casc_s0_r, casc_s1_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_s_r <= 2'h0;
            din_s_r <= 2'h0;
            alt_s_r <= 2'h0;
            req_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[0], serial_bit_clock};
            din_s_r <= {din_s_r[0], serial_data_in};
            alt_s_r <= {alt_s_r[0], alternate_serial_input};
            req_s_r <= {req_s_r[0], secondary_request_pin};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    // strap-like pins are synchronised too; a change mid-frame only takes
    // effect a couple of cycles later, which the host must allow for
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_s_r <= 2'h0;
            casc_s0_r <= 3'h0;
            casc_s1_r <= 3'h0;
        end else begin
            sel_s_r <= {sel_s_r[0], alt_input_select};
            casc_s0_r <= cascade_count;
            casc_s1_r <= casc_s0_r;
        end
    end

    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;

    // control registers 1..4 sit at index 0..3, index is register number minus one
    logic [7:0] ctrl_reg_r [NUM_REGS];
    logic [NUM_REGS-1:0] read_mode_r;
    wire dac16_mode = ctrl_reg_r[0][CR1_DAC16_BIT];

    // frame timing
    wire long_frame = (casc_s1_r >= 3'(CASCADE_LONG_MIN));
    wire [9:0] frame_len = long_frame ? FRAME_LONG : FRAME_SHORT;
    wire [9:0] sec_ofs = long_frame ? SEC_OFS_LONG : SEC_OFS_SHORT;

    logic [9:0] bit_cnt_r;
    logic [3:0] bit_idx_r;
    csp_phase_e phase_r;
    logic [15:0] shift_out_r, shift_in_r;
    logic [15:0] adc_word_r, dac_word_r;
    logic pending_r, dac_new_r;
    logic [15:0] frame_count_r;
    logic [2:0] dev_addr_r;
    logic fs_r, dout_r, oe_n_r;

    wire frame_wrap = (bit_cnt_r == frame_len - 10'h001);
    wire prim_go = sclk_rise & (bit_cnt_r == PRIM_START - 10'h001);
    // a request raised in this period's primary frame is served in the same period
    wire sec_go = sclk_rise & pending_r & (bit_cnt_r == sec_ofs);
    wire word_end = sclk_fall & (bit_idx_r == BIT_LAST);
    wire in_bit = sel_s_r[1] ? alt_s_r[1] : din_s_r[1];
    wire [15:0] in_word = {shift_in_r[14:0], in_bit};

    // decode of a finished control word
    wire [7:0] cw_upper = in_word[15:8];
    wire cw_idle = (cw_upper == CW_IDLE_UPPER);
    wire cw_read = in_word[CW_READ];
    wire [2:0] cw_reg = in_word[CW_REG_HI:CW_REG_LO];
    wire cw_mine = (in_word[CW_DEV_HI:CW_DEV_LO] == dev_addr_r);
    wire cw_valid_reg = (cw_reg != 3'h0) & (cw_reg <= 3'(NUM_REGS));
    wire [1:0] cw_idx = 2'(cw_reg - 3'h1);

    // software request only in 15-bit mode
    wire sw_req = ~dac16_mode & in_word[0];
    wire hw_req_rise = req_s_r[1] & (phase_r == PH_PRIM);

    function automatic logic [15:0] sec_reply(input logic [15:0] w, input logic [2:0] addr, input logic [7:0] val);
        sec_reply = {addr, 13'h0000};
        if (w[CW_READ]) begin
            sec_reply = {addr, 5'h00, val};
        end
    endfunction : sec_reply

    // apb decode, needed by the sample path below
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire apb_dac_rd = apb_acc & ~pwrite & (paddr == ADDR_DAC);

    // fields of a control word still coming in: after seven falling edges the
    // low end of the shifter holds device, read flag and register address
    wire [2:0] peek_dev = in_word[6:4];
    wire peek_read = in_word[3];
    wire [2:0] peek_reg = in_word[2:0];
    wire peek_ok = (peek_dev == dev_addr_r) & (peek_reg != 3'h0) & (peek_reg <= 3'(NUM_REGS));
    wire [1:0] peek_idx = 2'(peek_reg - 3'h1);
    wire [7:0] sec_peek = ctrl_reg_r[peek_idx];
    wire peek_load = sclk_fall & (phase_r == PH_SEC) & (bit_idx_r == 4'h6) & peek_read & peek_ok;

    // frame starts and ends
    wire prim_load = (phase_r == PH_IDLE) & prim_go;
    wire sec_load = (phase_r == PH_IDLE) & ~prim_go & sec_go;
    wire frame_load = prim_load | sec_load;
    wire frame_on = (phase_r == PH_PRIM) | (phase_r == PH_SEC);
    wire prim_done = word_end & (phase_r == PH_PRIM);
    wire sec_done = word_end & (phase_r == PH_SEC);
    wire [15:0] first_word = prim_load ? adc_word_r : sec_reply(16'h0000, dev_addr_r, 8'h00);

    // bit clocks since the primary frame start
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r <= 10'h000;
        end else if (sclk_rise) begin
            bit_cnt_r <= frame_wrap ? 10'h000 : bit_cnt_r + 10'h001;
        end
    end

    // phase of the link
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= PH_IDLE;
        end else begin
            case (phase_r)
                PH_IDLE: begin
                    if (prim_load) begin
                        phase_r <= PH_PRIM;
                    end else if (sec_load) begin
                        phase_r <= PH_SEC;
                    end
                end
                PH_PRIM, PH_SEC: begin
                    if (word_end) begin
                        phase_r <= PH_IDLE;
                    end
                end
                default: begin
                    phase_r <= PH_IDLE;
                end
            endcase
        end
    end

    // frame sync and output enable follow the frame
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fs_r <= 1'b1;
            oe_n_r <= 1'b1;
        end else if (frame_load) begin
            fs_r <= 1'b0;
            oe_n_r <= 1'b0;
        end else if (frame_on & word_end) begin
            fs_r <= 1'b1;
            oe_n_r <= 1'b1;
        end
    end

    // the first bit goes out with frame sync so the host's first falling edge sees it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dout_r <= 1'b0;
            shift_out_r <= 16'h0000;
        end else if (frame_load) begin
            dout_r <= first_word[15];
            shift_out_r <= {first_word[14:0], 1'b0};
        end else if (frame_on & sclk_rise) begin
            dout_r <= shift_out_r[15];
            shift_out_r <= {shift_out_r[14:0], 1'b0};
        end else if (peek_load) begin
            // seven bits are out, so the low byte sits just below the top bit
            shift_out_r[14:7] <= sec_peek;
        end
    end

    // input shifter and bit position in the word
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_in_r <= 16'h0000;
            bit_idx_r <= 4'h0;
        end else if (frame_load) begin
            bit_idx_r <= 4'h0;
        end else if (frame_on & sclk_fall) begin
            shift_in_r <= in_word;
            bit_idx_r <= bit_idx_r + 4'h1;
        end
    end

    // a register is written only at the end of a secondary word for this device
    wire reg_write = sec_done & cw_mine & ~cw_idle & cw_valid_reg & ~cw_read;
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{CR1_RESET, CR2_RESET, CR3_RESET, CR4_RESET};
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    ctrl_reg_r[gi] <= REG_RESET[gi];
                end else if (reg_write && cw_idx == 2'(gi)) begin
                    ctrl_reg_r[gi] <= in_word[CW_DATA_HI:CW_DATA_LO];
                end
            end
        end
    endgenerate

    // any secondary word for this device leaves at most the one register it reads in read mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            read_mode_r <= 4'h0;
        end else if (sec_done & cw_mine) begin
            read_mode_r <= (!cw_idle && cw_valid_reg && cw_read) ? (4'h1 << cw_idx) : 4'h0;
        end
    end

    // a new request wins over the clear; the request pin is only sampled while a primary frame is on
    wire new_req = hw_req_rise | (prim_done & sw_req);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pending_r <= 1'b0;
        end else if (new_req) begin
            pending_r <= 1'b1;
        end else if (sec_done) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dac_word_r <= 16'h0000;
            dac_new_r <= 1'b0;
        end else if (prim_done) begin
            // 15-bit sample keeps d15..d1 and a zero lsb
            dac_word_r <= dac16_mode ? in_word : {in_word[15:1], 1'b0};
            dac_new_r <= 1'b1;
        end else if (apb_dac_rd) begin
            dac_new_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frame_count_r <= 16'h0000;
        end else if (prim_load) begin
            frame_count_r <= frame_count_r + 16'h0001;
        end
    end

    // apb slave, no wait states: pready answers in the first access cycle
    logic [15:0] adc_nxt;
    assign adc_nxt = (apb_wr && paddr == ADDR_ADC) ? pwdata[15:0] : adc_word_r;
    wire is_reg = (paddr >= ADDR_REGS) & (paddr < ADDR_REGS + 8'h10) & (paddr[1:0] == 2'h0);
    wire [1:0] reg_sel = paddr[3:2];
    wire mapped = is_reg | (paddr == ADDR_ADC) | (paddr == ADDR_DAC) | (paddr == ADDR_STATUS) |
        (paddr == ADDR_CFG);
    wire [31:0] status_word = {frame_count_r, 12'h000, dac16_mode, |read_mode_r, dac_new_r, pending_r};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_ADC: rd_mux = {16'h0000, adc_word_r};
            ADDR_DAC: rd_mux = {16'h0000, dac_word_r};
            ADDR_STATUS: rd_mux = status_word;
            ADDR_CFG: rd_mux = {29'h0, dev_addr_r};
            default: rd_mux = is_reg ? {24'h0, ctrl_reg_r[reg_sel]} : 32'h0000_0000;
        endcase
    end

    // sample to send and this device's address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            adc_word_r <= 16'h0000;
            dev_addr_r <= DEV_ADDR_RESET;
        end else begin
            adc_word_r <= adc_nxt;
            if (apb_wr && paddr == ADDR_CFG) begin
                dev_addr_r <= pwdata[2:0];
            end
        end
    end

    // answer is registered from the setup cycle, so it costs no wait state and keeps outputs on flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    assign frame_sync_pulse = fs_r;
    assign serial_data_out = dout_r;
    assign serial_data_oe_n = oe_n_r;

endmodule : csp_serial_port
`default_nettype wire

//--- verilog/csp_pkg.sv
package csp_pkg;
    // word format on the serial link
    localparam int WORD_BITS = 16;
    localparam logic [3:0] BIT_LAST = 4'hF;
    // control word fields
    localparam int CW_DEV_HI = 15;
    localparam int CW_DEV_LO = 13;
    localparam int CW_READ = 12;
    localparam int CW_REG_HI = 11;
    localparam int CW_REG_LO = 9;
    localparam int CW_DATA_HI = 7;
    localparam int CW_DATA_LO = 0;
    localparam logic [7:0] CW_IDLE_UPPER = 8'h00;
    // control register 1 bit that selects the dac word length
    localparam int CR1_DAC16_BIT = 0;
    localparam logic [2:0] REG_CR1 = 3'h1;
    localparam int NUM_REGS = 4;
    // register reset values
    localparam logic [7:0] CR1_RESET = 8'h00;
    localparam logic [7:0] CR2_RESET = 8'h00;
    localparam logic [7:0] CR3_RESET = 8'h00;
    localparam logic [7:0] CR4_RESET = 8'h00;
    // frame timing in bit clocks
    localparam logic [9:0] FRAME_SHORT = 10'h100;
    localparam logic [9:0] FRAME_LONG = 10'h200;
    localparam logic [9:0] SEC_OFS_SHORT = 10'h080;
    localparam logic [9:0] SEC_OFS_LONG = 10'h100;
    localparam logic [9:0] PRIM_START = 10'h001;
    localparam int CASCADE_LONG_MIN = 5;
    // device address for a stand-alone part
    localparam logic [2:0] DEV_ADDR_RESET = 3'h0;
    // apb map
    localparam logic [7:0] ADDR_ADC = 8'h00;
    localparam logic [7:0] ADDR_DAC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    localparam logic [7:0] ADDR_REGS = 8'h10;
    localparam int ST_PENDING = 0;
    localparam int ST_DAC_NEW = 1;
    localparam int ST_READ_MODE = 2;
    localparam int ST_DAC16 = 3;
    localparam int ST_FRAME_CNT_LO = 8;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_PRIM = 2'b01,
        PH_SEC = 2'b10
    } csp_phase_e;
endpackage : csp_pkg

//--- test/csp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module csp_monitor (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_sync_pulse,
    input wire logic serial_data_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // high run saturates and starts full, so the first frame after reset passes
    logic [9:0] lo_r;
    logic [9:0] hi_r;
    wire logic [9:0] lo_nxt = frame_sync_pulse ? 10'h000 : lo_r + 10'h001;
    wire logic [9:0] hi_nxt = !frame_sync_pulse ? 10'h000 : hi_r + {9'h000, hi_r != 10'h3FF};
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lo_r <= 10'h000;
            hi_r <= 10'h3FF;
        end else begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
        end
    end
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_sel; pready |-> psel && penable; endproperty
    a_sel: assert property (p_sel) else $error("ready unasked");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_oe_on; $fell(frame_sync_pulse) |-> ##[0:2] !serial_data_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven");
    property p_oe_off; $rose(frame_sync_pulse) |-> ##[0:2] serial_data_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output not released");
    property p_len; $rose(frame_sync_pulse) |-> lo_r >= 10'h07B && lo_r <= 10'h07D; endproperty
    a_len: assert property (p_len) else $error("frame not 16 bits");
    property p_gap; $fell(frame_sync_pulse) |-> hi_r >= 10'h37C; endproperty
    a_gap: assert property (p_gap) else $error("frames too close");
    cover property ($fell(frame_sync_pulse));
    cover property (pslverr);
    cover property (lo_r == 10'h07C);
endmodule : csp_monitor
bind csp_serial_port csp_monitor mon (.sys_clk, .resetn, .psel, .penable, .pready, .pslverr,
    .frame_sync_pulse, .serial_data_oe_n);
`default_nettype wire

//--- test/csp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_host_model (
    input wire logic frame_sync_pulse,
    input wire logic serial_data_out,
    input wire logic alt_input_select,
    input wire logic [15:0] tx_word,
    output logic serial_bit_clock,
    output logic [15:0] rx_word,
    output logic serial_data_in,
    output logic alternate_serial_input,
    output int frames,
    output int gap
);
    int idx = 0;
    int rises = 0;
    int st_at = 0;
    logic cur = 1'b0;
    // the unused input carries the inverse, so a wrong pick shows
    assign serial_data_in = alt_input_select ? ~cur : cur;
    assign alternate_serial_input = alt_input_select ? cur : ~cur;
    initial begin
        serial_bit_clock = 1'b0;
        frames = 0;
        gap = 0;
        rx_word = 16'h0000;
        #17;
        forever #400 serial_bit_clock = ~serial_bit_clock;
    end
    // shift on our own rise so data is settled at the device's falling edge
    always @(posedge serial_bit_clock) begin
        rises++;
        cur = tx_word[4'hF - idx[3:0]];
    end
    always @(negedge serial_bit_clock) begin
        if (!frame_sync_pulse) begin
            if (idx == 0) begin
                gap = rises - st_at;
                st_at = rises;
            end
            rx_word[4'hF - idx[3:0]] = serial_data_out;
            idx++;
            if (idx == 16) begin
                idx = 0;
                frames++;
            end
        end
    end
endmodule : csp_host_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import csp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic alt_input_select = 1'b0;
    logic secondary_request_pin = 1'b0;
    logic [2:0] cascade_count = 3'h0;
    logic [15:0] tx_word = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, frame_sync_pulse, serial_data_out, serial_data_oe_n;
    logic serial_bit_clock, serial_data_in, alternate_serial_input, err;
    logic [15:0] rx_word, adc, dac, rx;
    logic [31:0] q;
    logic [2:0] dev;
    logic [7:0] d;
    int frames, gap;
    int fail_count = 0, comparisons = 0, seed = 94779, cyc = 0;
    csp_serial_port dut (.sys_clk, .resetn, .serial_bit_clock, .serial_data_in, .alternate_serial_input,
        .alt_input_select, .secondary_request_pin, .cascade_count, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .frame_sync_pulse, .serial_data_out, .serial_data_oe_n);
    csp_host_model host (.frame_sync_pulse, .serial_data_out, .alt_input_select, .tx_word,
        .serial_bit_clock, .rx_word, .serial_data_in, .alternate_serial_input, .frames, .gap);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rdc
    function automatic logic [15:0] cw(input logic rd, input logic [2:0] r, input logic [7:0] v);
        return {dev, rd, r, 1'b0, v};
    endfunction : cw
    task automatic frame(input logic [15:0] w);
        int n;
        n = frames;
        tx_word <= w;
        while (frames == n) @(posedge sys_clk);
        // let the bit-clock synchroniser catch up before looking at status
        repeat (4) @(posedge sys_clk);
        rx = rx_word;
    endtask : frame
    task automatic prim(input logic sw);
        adc = 16'($random(seed));
        dac = 16'($random(seed));
        dac[0] = sw;
        apb(1'b1, ADDR_ADC, {16'h0, adc});
        frame(dac);
        chk({16'h0, rx}, {16'h0, adc});
    endtask : prim
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        dev = 3'($random(seed)) | 3'h1;
        rdc(ADDR_STATUS, 32'hF, 32'h0);
        rdc(ADDR_REGS, 32'hFF, {24'h0, CR1_RESET});
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_CFG, {29'h0, dev});
        frame(16'h0000);
        prim(1'b0);
        rdc(ADDR_STATUS, 32'h1, 32'h0);
        rdc(ADDR_DAC, 32'hFFFF, {16'h0, dac[15:1], 1'b0});
        $display("test primary done");
        d = 8'($random(seed));
        prim(1'b1);
        rdc(ADDR_STATUS, 32'h1, 32'h1);
        frame(cw(1'b0, 3'h2, d));
        chk({16'h0, rx}, {16'h0, dev, 13'h0});
        chk(gap, 32'h80);
        rdc(ADDR_REGS + 8'h4, 32'hFF, {24'h0, d});
        rdc(ADDR_STATUS, 32'h1, 32'h0);
        $display("test software request done");
        secondary_request_pin <= 1'b1;
        prim(1'b0);
        secondary_request_pin <= 1'b0;
        alt_input_select <= 1'b1;
        frame(cw(1'b1, 3'h2, ~d));
        alt_input_select <= 1'b0;
        chk({24'h0, rx[7:0]}, {24'h0, d});
        rdc(ADDR_REGS + 8'h4, 32'hFF, {24'h0, d});
        rdc(ADDR_STATUS, 32'h4, 32'h4);
        prim(1'b1);
        frame({8'h00, ~d});
        rdc(ADDR_REGS + 8'h4, 32'hFF, {24'h0, d});
        $display("test read and idle done");
        prim(1'b1);
        frame(cw(1'b0, REG_CR1, 8'h01));
        rdc(ADDR_STATUS, 32'hC, 32'h8);
        prim(1'b1);
        rdc(ADDR_DAC, 32'hFFFF, {16'h0, dac});
        rdc(ADDR_STATUS, 32'h1, 32'h0);
        prim(1'b0);
        chk(gap, 32'h100);
        $display("test dac length done");
        cascade_count <= 3'(CASCADE_LONG_MIN);
        prim(1'b0);
        secondary_request_pin <= 1'b1;
        prim(1'b0);
        secondary_request_pin <= 1'b0;
        frame(cw(1'b0, 3'h3, d));
        chk(gap, 32'h100);
        rdc(ADDR_REGS + 8'h8, 32'hFF, {24'h0, d});
        prim(1'b0);
        prim(1'b0);
        chk(gap, 32'h200);
        $display("test cascade timing done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
